// file: rtl/adc_port_regs.svh
// constants for the converter serial read port
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH
`define WORD_BITS 16
`define LEAD_ZEROS 4
`define TRACK_AFTER_FALLS 13
`define LAST_LAUNCH_FALL 15
`define FRAME_FALLS 16
`define PD_MIN_FALLS 2
`define PD_MAX_FALLS 10
`define WAKE_FALLS 10
`define RESULT_WIDTH 12
`endif

// file: rtl/adc_port_pkg.sv
// types for the converter serial read port
package adc_port_pkg;
	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_DOWN
	} pwr_mode_e;
	typedef logic [4:0] fall_cnt_t;
endpackage

// file: rtl/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and synchronised copies
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_q
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage;
	// reset to ones, the idle level of the link pins, so no false edge follows reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '1;
			pin_sync_q <= '1;
		end else begin
			meta_q <= pin_in;
			pin_sync_q <= meta_q;
		end
	end
endmodule

// file: rtl/adc_serial_read_port.sv
// serial read port and conversion sequencer of a sampling converter
`timescale 1ns/10ps
`include "adc_port_regs.svh"

module adc_serial_read_port
	import adc_port_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	// converter core
	input wire logic [`RESULT_WIDTH-1:0] result_in,
	output logic sample_hold_q,
	output logic powered_q,
	// serial data pin, enable low while driving
	output logic serial_result_out,
	output logic serial_result_oe_n
);
	logic [1:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic cs_n_prev_q;
	logic sclk_prev_q;
	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic sclk_rise;
	fall_cnt_t falls_q;
	logic active_q;
	logic [`WORD_BITS-1:0] shift_q;
	logic drive_q;
	logic track_pending_q;
	pwr_mode_e mode_q;
	logic waking_q;

	// pad a result of up to 12 bits into the 16-bit frame word
	function automatic logic [`WORD_BITS-1:0] frame_word(input logic [`RESULT_WIDTH-1:0] r);
		logic [`WORD_BITS-1:0] w;
		w = '0;
		w[`WORD_BITS-`LEAD_ZEROS-1 -: `RESULT_WIDTH] = r;
		return w;
	endfunction

	// ----------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------
	pin_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in({cs_n, sclk}),
		.pin_sync_q(pins_s)
	);
	assign cs_n_s = pins_s[1];
	assign sclk_s = pins_s[0];

	// history resets to the idle-high pin level, matching the synchroniser, so no phantom frame starts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_prev_q <= 1'b1;
			sclk_prev_q <= 1'b1;
		end else begin
			cs_n_prev_q <= cs_n_s;
			sclk_prev_q <= sclk_s;
		end
	end
	assign cs_fall = cs_n_prev_q & ~cs_n_s;
	assign cs_rise = ~cs_n_prev_q & cs_n_s;
	// serial clock edges count only inside a frame
	assign sclk_fall = sclk_prev_q & ~sclk_s & ~cs_n_s;
	assign sclk_rise = ~sclk_prev_q & sclk_s & ~cs_n_s;

	// ----------------------------------------
	// frame sequencing
	// ----------------------------------------
	// falling edge count; saturates at 16 so extra clocks do nothing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			falls_q <= '0;
			active_q <= 1'b0;
		end else if (cs_fall) begin
			falls_q <= '0;
			active_q <= 1'b1;
		end else if (cs_rise) begin
			active_q <= 1'b0;
		end else if (active_q && sclk_fall) begin
			falls_q <= falls_q + 5'd1;
			if (falls_q == 5'(`FRAME_FALLS - 1)) begin
				active_q <= 1'b0;
			end
		end
	end

	// output shifter: first zero at cs fall, next bit per falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
		end else if (cs_fall) begin
			shift_q <= frame_word(result_in);
		end else if (active_q && sclk_fall) begin
			shift_q <= {shift_q[`WORD_BITS-2:0], 1'b0};
		end
	end
	assign serial_result_out = shift_q[`WORD_BITS-1];

	// output driver; the pin enable is its own flop so the port has no gate behind it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_q <= 1'b0;
			serial_result_oe_n <= 1'b1;
		end else if (cs_fall) begin
			drive_q <= 1'b1;
			serial_result_oe_n <= 1'b0;
		end else if (cs_rise) begin
			drive_q <= 1'b0;
			serial_result_oe_n <= 1'b1;
		end else if (active_q && sclk_fall && falls_q == 5'(`FRAME_FALLS - 1)) begin
			drive_q <= 1'b0;
			serial_result_oe_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// track and hold control
	// ----------------------------------------
	// hold at cs fall; track on the rising edge after the 13th fall,
	// or on the first edge when waking from power-down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_hold_q <= 1'b0;
			track_pending_q <= 1'b0;
		end else if (cs_fall) begin
			sample_hold_q <= 1'b1;
			track_pending_q <= 1'b0;
		end else begin
			if (active_q && sclk_fall && falls_q == 5'(`TRACK_AFTER_FALLS - 1)) begin
				track_pending_q <= 1'b1;
			end
			if (track_pending_q && sclk_rise) begin
				sample_hold_q <= 1'b0;
				track_pending_q <= 1'b0;
			end
			if (waking_q && active_q && (sclk_rise || sclk_fall) && falls_q == '0) begin
				sample_hold_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// power mode
	// ----------------------------------------
	// a short frame may only be a glitch, so below two falls nothing changes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= PWR_NORMAL;
			waking_q <= 1'b0;
		end else if (cs_fall) begin
			waking_q <= (mode_q == PWR_DOWN);
		end else if (cs_rise && active_q) begin
			if (falls_q >= 5'(`PD_MIN_FALLS) && falls_q < 5'(`PD_MAX_FALLS)) begin
				mode_q <= PWR_DOWN;
			end
			waking_q <= 1'b0;
		end else if (active_q && sclk_fall && falls_q == 5'(`WAKE_FALLS - 1)) begin
			mode_q <= PWR_NORMAL;
		end
	end

	// fully powered only when normal and no wake frame is still running
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			powered_q <= 1'b1;
		end else begin
			powered_q <= (mode_q == PWR_NORMAL) && !(waking_q && active_q);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_cs_fall_drive: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall |=> drive_q && sample_hold_q)
		else $error("driver or hold not set after chip-select fall");
	a_abort_release: assert property (@(posedge clk) disable iff (!rst_n)
		cs_rise |=> !drive_q && !active_q)
		else $error("output not released on early chip-select rise");
	a_full_release: assert property (@(posedge clk) disable iff (!rst_n)
		(active_q && sclk_fall && falls_q == 5'd15 && !cs_rise && !cs_fall) |=> !drive_q && falls_q == 5'd16)
		else $error("output not released on sixteenth fall");
	a_first_zero: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall |=> serial_result_out == 1'b0)
		else $error("first bit is not a leading zero");
	a_shift_step: assert property (@(posedge clk) disable iff (!rst_n)
		(active_q && sclk_fall && !cs_fall && !cs_rise) |=> shift_q == {$past(shift_q[14:0]), 1'b0})
		else $error("shifter did not advance one bit");
	a_pd_enter: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise && active_q && falls_q >= 5'd2 && falls_q < 5'd10) |=> mode_q == PWR_DOWN)
		else $error("power-down not entered");
	a_glitch_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise && falls_q < 5'd2 && mode_q == PWR_NORMAL) |=> mode_q == PWR_NORMAL)
		else $error("glitch frame changed the power mode");
	a_wake_up: assert property (@(posedge clk) disable iff (!rst_n)
		(active_q && sclk_fall && falls_q == 5'd9 && !cs_rise && !cs_fall) |=> mode_q == PWR_NORMAL)
		else $error("device did not wake after tenth fall");
	a_track_return: assert property (@(posedge clk) disable iff (!rst_n)
		(track_pending_q && sclk_rise && !cs_fall) |=> !sample_hold_q)
		else $error("sampler not back in track");
	c_full_frame: cover property (@(posedge clk) disable iff (!rst_n)
		active_q && sclk_fall && falls_q == 5'd15);
	c_power_down: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(mode_q == PWR_DOWN));
	c_wake: cover property (@(posedge clk) disable iff (!rst_n)
		$fell(mode_q == PWR_DOWN));
endmodule

// file: verif/host_model.sv
// host serial master that frames and clocks the converter read port
`timescale 1ns/10ps
module host_model (
	// system clock
	input wire logic clk,
	// device data pin, its enable and the sampler state
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic hold,
	// link pins
	output logic cs_n,
	output logic sclk
);
	logic last_q = 1'b0;
	logic [15:0] word_q;
	logic [15:0] rise_q;
	logic hold13_q;
	logic hold15_q;
	logic oe_end_q;
	// no pull on the data line: released, it shows the inverse of the last driven bit
	wire logic line = dout_oe_n ? ~last_q : dout;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
	end
	// remember the last driven bit
	always @(posedge clk) begin
		if (!dout_oe_n)
			last_q <= dout;
	end
	// one frame of n clocks, sclk idle high and still outside frames
	task frame(input int n);
		int k;
		@(posedge clk) cs_n <= 1'b0;
		for (k = 1; k <= n; k++) begin
			repeat (12) @(posedge clk);
			word_q <= {word_q[14:0], line}; // bit taken at each falling edge
			if (k == 1)
				rise_q <= {15'h0000, line}; // slow reader takes the first zero on a fall
			if (k == 13)
				hold13_q <= hold;
			if (k == 15)
				hold15_q <= hold;
			sclk <= 1'b0;
			repeat (13) @(posedge clk);
			// slow reader: the rest on rising edges, last bit on the 15th
			if (k <= 15)
				rise_q <= {rise_q[14:0], line};
			sclk <= 1'b1;
		end
		repeat (8) @(posedge clk);
		oe_end_q <= dout_oe_n;
		cs_n <= 1'b1; // short frames end early
		// quiet gap; with the caller's setup edge a frame spans 25*(n+1) clocks,
		// so frame starts stay a whole number of serial clock periods apart
		repeat (15) @(posedge clk);
	endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the converter serial read port
`timescale 1ns/10ps
`include "adc_port_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t mismatch", $time); end end
module tb;
	import adc_port_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [`RESULT_WIDTH-1:0] result_in = 12'h000;
	logic cs_n, sclk, sample_hold_q, powered_q, serial_result_out, serial_result_oe_n;
	int n_fail = 0;
	int comparisons = 0;
	int seed = 82948;
	int pwr = 1;
	int was;
	int falls[11] = '{16, 1, 10, 2, 9, 10, 9, 16, 16, 8, 16};
	logic [31:0] rnd;
	logic [`WORD_BITS-1:0] exp_q[$];
	logic [`WORD_BITS-1:0] exp_w;
	// ------------------------------------------------------------
	// clock, parts
	// ------------------------------------------------------------
	always #2.5 clk = ~clk;
	adc_serial_read_port dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .result_in(result_in),
		.sample_hold_q(sample_hold_q), .powered_q(powered_q), .serial_result_out(serial_result_out),
		.serial_result_oe_n(serial_result_oe_n));
	host_model host (.clk(clk), .dout(serial_result_out), .dout_oe_n(serial_result_oe_n),
		.hold(sample_hold_q), .cs_n(cs_n), .sclk(sclk));
	task give_verdict();
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog: 22 frames of at most 425 cycles each fit well inside this span
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		give_verdict();
	end
	// ------------------------------------------------------------
	// main sequence: model power state kept as an integer
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 11; i++) begin
				rnd = $random(seed);
				// expected word: four zeros then the result
				exp_q.push_back({4'h0, rnd[`RESULT_WIDTH-1:0]});
				@(posedge clk) result_in <= rnd[`RESULT_WIDTH-1:0];
				was = pwr;
				host.frame(falls[i]);
				exp_w = exp_q.pop_front();
				if (was == 1 && falls[i] >= 2 && falls[i] <= 9)
					pwr = 0;
				if (was == 0 && falls[i] >= 10)
					pwr = 1;
				if (was == 1 && falls[i] == 16) begin
					`CHK(host.word_q, exp_w)
					`CHK(host.rise_q, exp_w)
					`CHK(host.hold13_q, 1'b1)
					`CHK(host.hold15_q, 1'b0)
				end
				`CHK(host.oe_end_q, (falls[i] >= 16) ? 1'b1 : 1'b0)
				`CHK(serial_result_oe_n, 1'b1)
				`CHK(powered_q, (pwr == 1) ? 1'b1 : 1'b0)
			end
		end
		give_verdict();
	end
endmodule
